// >>> mbpt_count.sv
`include "mbpt_defs.svh"
`default_nettype none

module mbpt_count (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic step,
    input wire logic run,
    input wire logic clear,
    input wire logic wrap,
    input wire logic [`MBPT_W-1:0] presc_max,
    output logic tick,
    output logic [`MBPT_W-1:0] count_q
);
    logic [`MBPT_W-1:0] presc_q;
    logic [`MBPT_W-1:0] presc_d;
    logic [`MBPT_W-1:0] count_d;

    // ****************************************************************
    // Prescaler and counter.
    // ****************************************************************
    always_comb begin
        tick = step && run && (presc_q == presc_max);
        presc_d = presc_q;
        count_d = count_q;
        if (clear) begin
            presc_d = `MBPT_ZERO;
            count_d = `MBPT_ZERO;
        end else if (step && run) begin
            if (tick) begin
                presc_d = `MBPT_ZERO;
                count_d = wrap ? `MBPT_ZERO : count_q + `MBPT_ONE;
            end else begin
                presc_d = presc_q + `MBPT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_q <= `MBPT_ZERO;
            count_q <= `MBPT_ZERO;
        end else if (clk_en) begin
            presc_q <= presc_d;
            count_q <= count_d;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_count_inc;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && tick && !wrap && !clear) |=> (count_q == $past(count_q) + `MBPT_ONE);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("Count did not advance.");

    property p_no_step;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && !step && !clear) |=> $stable(count_q) && $stable(presc_q);
    endproperty
    a_no_step: assert property (p_no_step) else $error("Count moved without a step.");
endmodule

`default_nettype wire

// >>> mbpt_defs.svh
`ifndef MBPT_DEFS_SVH
`define MBPT_DEFS_SVH

// ****************************************************************
// Widths and counts.
// ****************************************************************
`define MBPT_W 32
`define MBPT_NMATCH 7
`define MBPT_NCAP 4
`define MBPT_NEXT 4
`define MBPT_NPWM 6
`define MBPT_NFLAG 11

// ****************************************************************
// Per-match control field, three bits for each match register.
// ****************************************************************
`define MBPT_MC_W 3
`define MBPT_MC_INT 0
`define MBPT_MC_RST 1
`define MBPT_MC_STOP 2

// ****************************************************************
// External match output actions, two bits for each output.
// ****************************************************************
`define MBPT_EM_NOP 2'h0
`define MBPT_EM_LOW 2'h1
`define MBPT_EM_HIGH 2'h2
`define MBPT_EM_TOG 2'h3

// ****************************************************************
// Count source select codes.
// ****************************************************************
`define MBPT_CM_TIMER 2'h0
`define MBPT_CM_RISE 2'h1
`define MBPT_CM_FALL 2'h2
`define MBPT_CM_BOTH 2'h3

// ****************************************************************
// Reset values and constants.
// ****************************************************************
`define MBPT_ZERO 32'h0
`define MBPT_ONE 32'h1
`define MBPT_CYCLE_IDX 0

`endif

// >>> mbpt_edge.sv
`include "mbpt_defs.svh"
`default_nettype none

module mbpt_edge (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [`MBPT_NCAP-1:0] cap_in,
    output logic [`MBPT_NCAP-1:0] rise,
    output logic [`MBPT_NCAP-1:0] fall
);
    logic [`MBPT_NCAP-1:0] prev_q;
    logic [`MBPT_NCAP-1:0] prev_d;

    // ****************************************************************
    // Edge detection per capture input.
    // ****************************************************************
    genvar k;
    generate
        for (k = 0; k < `MBPT_NCAP; k = k + 1) begin : g_ch
            always_comb begin
                prev_d[k] = cap_in[k];
                rise[k] = cap_in[k] && !prev_q[k];
                fall[k] = !cap_in[k] && prev_q[k];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= '0;
        end else if (clk_en) begin
            prev_q <= prev_d;
        end
    end
endmodule

`default_nettype wire

// >>> mbpt_load.sv
`default_nettype none

module mbpt_load (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [5:0] pwm,
    input wire logic [2:0] sel,
    output logic meas_vld,
    output logic [31:0] meas_per,
    output logic [31:0] meas_high
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_q;
    logic seen_q;
    logic [31:0] per_q;
    logic [31:0] high_q;

    // ****************************************************************
    // Load stage: reports period and high time of one line, rise to rise.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        meas_vld <= 1'b0;
        prev_q <= pwm[sel];
        if (rst) begin
            seen_q <= 1'b0;
            per_q <= 32'h0;
            high_q <= 32'h0;
        end else if (pwm[sel] && !prev_q) begin
            meas_vld <= seen_q;
            meas_per <= per_q;
            meas_high <= high_q;
            seen_q <= 1'b1;
            per_q <= 32'h1;
            high_q <= 32'h1;
        end else begin
            per_q <= per_q + 32'h1;
            high_q <= high_q + {31'h0, pwm[sel]};
        end
    end
endmodule

`default_nettype wire

// >>> mbpt_pkg.sv
`default_nettype none

package mbpt_pkg;
    typedef enum logic [3:0] {
        MBPT_SRC_TIMER = 4'h1,
        MBPT_SRC_RISE = 4'h2,
        MBPT_SRC_FALL = 4'h4,
        MBPT_SRC_BOTH = 4'h8
    } mbpt_src_e;
endpackage

`default_nettype wire

// >>> mbpt_timer.sv
// Operation
// - Prescaler terminal count advances 32-bit counter.
// - Count clock or capture input transitions.
// - Seven match registers feed six outputs.
// - Match action continue, stop or reset, interrupt.
// - Cycle match register returns count to zero.
// - Single-edge outputs rise at cycle start.
// - Single-edge output falls at own match.
// - Double-edge output set and cleared by matches.
// - Edge order gives positive or negative pulse.
// - All PWM outputs share the cycle period.
// - Period and width are any count.
// - Released match values apply at cycle boundary while running in PWM mode.
// - Without PWM mode, plain timer only.
// - Sync master leads, sync slave follows.
// - Capture edge copies count, optional interrupt.
// - External match outputs low, high, toggle, hold.
`include "mbpt_defs.svh"
`default_nettype none

module mbpt_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic run_req,
    input wire logic counter_reset,
    input wire logic sync_follow,
    input wire logic sync_run_in,
    input wire logic [1:0] src_mode,
    input wire logic [1:0] src_sel,
    input wire logic [`MBPT_W-1:0] presc_max,
    input wire logic pwm_mode,
    input wire logic [`MBPT_NPWM-1:0] pwm_dbl,
    input wire logic [`MBPT_NPWM-1:0] pwm_out_en,
    input wire logic match_wr_stb,
    input wire logic [2:0] match_wr_idx,
    input wire logic [`MBPT_W-1:0] match_wr_data,
    input wire logic [`MBPT_NMATCH-1:0] match_release,
    input wire logic [`MBPT_NMATCH*`MBPT_MC_W-1:0] match_ctrl,
    input wire logic [2*`MBPT_NEXT-1:0] ext_action,
    input wire logic [`MBPT_NCAP-1:0] cap_in,
    input wire logic [`MBPT_NCAP-1:0] cap_rise_en,
    input wire logic [`MBPT_NCAP-1:0] cap_fall_en,
    input wire logic [`MBPT_NCAP-1:0] cap_int_en,
    input wire logic [`MBPT_NFLAG-1:0] flag_clear,
    output logic [`MBPT_W-1:0] count_q,
    output logic [`MBPT_NPWM-1:0] pwm_out_q,
    output logic [`MBPT_NEXT-1:0] ext_match_q,
    output logic [`MBPT_NCAP*`MBPT_W-1:0] cap_val_q,
    output logic [`MBPT_NFLAG-1:0] flags_q,
    output logic irq_q,
    output logic sync_run_out_q,
    output logic halted_q,
    output logic [`MBPT_NMATCH-1:0] release_q
);
    mbpt_pkg::mbpt_src_e src_e;
    logic step;
    logic tick;
    logic wrap;
    logic stop;
    logic run_src;
    logic run_eff;
    logic boundary;
    logic run_req_q;
    logic run_req_d;
    logic halted_d;
    logic irq_d;
    logic [`MBPT_NCAP-1:0] rise;
    logic [`MBPT_NCAP-1:0] fall;
    logic [`MBPT_NCAP-1:0] cap_ev;
    logic [`MBPT_NMATCH-1:0] hit;
    logic [`MBPT_NMATCH-1:0] int_bit;
    logic [`MBPT_NMATCH-1:0] rst_bit;
    logic [`MBPT_NMATCH-1:0] stop_bit;
    logic [`MBPT_NMATCH-1:0] release_d;
    logic [`MBPT_NFLAG-1:0] flag_set;
    logic [`MBPT_NFLAG-1:0] flags_d;
    logic [`MBPT_NMATCH-1:0][`MBPT_W-1:0] shadow_q;
    logic [`MBPT_NMATCH-1:0][`MBPT_W-1:0] shadow_d;
    logic [`MBPT_NMATCH-1:0][`MBPT_W-1:0] active_q;
    logic [`MBPT_NMATCH-1:0][`MBPT_W-1:0] active_d;
    logic [`MBPT_NPWM-1:0] pwm_d;
    logic [`MBPT_NEXT-1:0] ext_d;
    logic [`MBPT_NCAP*`MBPT_W-1:0] cap_val_d;

    // ****************************************************************
    // Capture edges and counter core.
    // ****************************************************************
    mbpt_edge u_edge (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .cap_in(cap_in),
        .rise(rise),
        .fall(fall)
    );

    mbpt_count u_count (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .step(step),
        .run(run_eff),
        .clear(counter_reset),
        .wrap(wrap),
        .presc_max(presc_max),
        .tick(tick),
        .count_q(count_q)
    );

    // ****************************************************************
    // Count source, run control and sync.
    // ****************************************************************
    always_comb begin
        src_e = mbpt_pkg::MBPT_SRC_TIMER;
        unique case (src_mode)
            `MBPT_CM_TIMER: src_e = mbpt_pkg::MBPT_SRC_TIMER;
            `MBPT_CM_RISE: src_e = mbpt_pkg::MBPT_SRC_RISE;
            `MBPT_CM_FALL: src_e = mbpt_pkg::MBPT_SRC_FALL;
            `MBPT_CM_BOTH: src_e = mbpt_pkg::MBPT_SRC_BOTH;
        endcase
        step = 1'b0;
        unique case (src_e)
            mbpt_pkg::MBPT_SRC_TIMER: step = 1'b1;
            mbpt_pkg::MBPT_SRC_RISE: step = rise[src_sel];
            mbpt_pkg::MBPT_SRC_FALL: step = fall[src_sel];
            mbpt_pkg::MBPT_SRC_BOTH: step = rise[src_sel] || fall[src_sel];
        endcase
        run_req_d = run_req;
        run_src = sync_follow ? sync_run_in : run_req_q;
        run_eff = run_src && !halted_q;
        wrap = |(hit & rst_bit);
        stop = |(hit & stop_bit);
        halted_d = halted_q;
        if (!run_src || counter_reset) begin
            halted_d = 1'b0;
        end
        if (stop) begin
            halted_d = 1'b1;
        end
        boundary = !pwm_mode || !run_eff || hit[`MBPT_CYCLE_IDX];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run_req_q <= 1'b0;
            sync_run_out_q <= 1'b0;
            halted_q <= 1'b0;
        end else if (clk_en) begin
            run_req_q <= run_req_d;
            sync_run_out_q <= run_req_d;
            halted_q <= halted_d;
        end
    end

    // ****************************************************************
    // Match registers with shadow copies and release bits.
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `MBPT_NMATCH; i = i + 1) begin : g_match
            always_comb begin
                int_bit[i] = match_ctrl[i*`MBPT_MC_W + `MBPT_MC_INT];
                rst_bit[i] = match_ctrl[i*`MBPT_MC_W + `MBPT_MC_RST];
                stop_bit[i] = match_ctrl[i*`MBPT_MC_W + `MBPT_MC_STOP];
                hit[i] = tick && (count_q == active_q[i]);
                shadow_d[i] = shadow_q[i];
                if (match_wr_stb && (match_wr_idx == 3'(i))) begin
                    shadow_d[i] = match_wr_data;
                end
                active_d[i] = active_q[i];
                release_d[i] = release_q[i];
                if (boundary && release_q[i]) begin
                    active_d[i] = shadow_q[i];
                    release_d[i] = 1'b0;
                end
                if (match_release[i]) begin
                    release_d[i] = 1'b1;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    shadow_q[i] <= `MBPT_ZERO;
                    active_q[i] <= `MBPT_ZERO;
                    release_q[i] <= 1'b0;
                end else if (clk_en) begin
                    shadow_q[i] <= shadow_d[i];
                    active_q[i] <= active_d[i];
                    release_q[i] <= release_d[i];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // PWM outputs.
    // ****************************************************************
    genvar j;
    generate
        for (j = 0; j < `MBPT_NPWM; j = j + 1) begin : g_pwm
            logic dbl;
            logic set_ev;
            logic clr_ev;
            always_comb begin
                dbl = (j > 0) && pwm_dbl[j];
                set_ev = dbl ? hit[j] : hit[`MBPT_CYCLE_IDX];
                if (!dbl && (active_q[j+1] == `MBPT_ZERO)) begin
                    set_ev = 1'b0;
                end
                clr_ev = hit[j+1];
                pwm_d[j] = pwm_out_q[j];
                if (!pwm_mode || !pwm_out_en[j]) begin
                    pwm_d[j] = 1'b0;
                end else if (clr_ev) begin
                    pwm_d[j] = 1'b0;
                end else if (set_ev) begin
                    pwm_d[j] = 1'b1;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // External match outputs.
    // ****************************************************************
    genvar e;
    generate
        for (e = 0; e < `MBPT_NEXT; e = e + 1) begin : g_ext
            always_comb begin
                ext_d[e] = ext_match_q[e];
                if (hit[e]) begin
                    unique case (ext_action[2*e +: 2])
                        `MBPT_EM_NOP: ext_d[e] = ext_match_q[e];
                        `MBPT_EM_LOW: ext_d[e] = 1'b0;
                        `MBPT_EM_HIGH: ext_d[e] = 1'b1;
                        `MBPT_EM_TOG: ext_d[e] = !ext_match_q[e];
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Capture registers.
    // ****************************************************************
    genvar k;
    generate
        for (k = 0; k < `MBPT_NCAP; k = k + 1) begin : g_cap
            always_comb begin
                cap_ev[k] = (rise[k] && cap_rise_en[k]) || (fall[k] && cap_fall_en[k]);
                cap_val_d[k*`MBPT_W +: `MBPT_W] = cap_val_q[k*`MBPT_W +: `MBPT_W];
                if (cap_ev[k]) begin
                    cap_val_d[k*`MBPT_W +: `MBPT_W] = count_q;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Event flags and interrupt request.
    // ****************************************************************
    always_comb begin
        flag_set = {cap_ev & cap_int_en, hit & int_bit};
        flags_d = (flags_q & ~flag_clear) | flag_set;
        irq_d = |flags_d;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwm_out_q <= '0;
            ext_match_q <= '0;
            cap_val_q <= '0;
            flags_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            pwm_out_q <= pwm_d;
            ext_match_q <= ext_d;
            cap_val_q <= cap_val_d;
            flags_q <= flags_d;
            irq_q <= irq_d;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence s_cycle_end;
        clk_en && pwm_mode && hit[`MBPT_CYCLE_IDX];
    endsequence

    sequence s_idle_mid_cycle;
        clk_en && pwm_mode && run_eff && !hit[`MBPT_CYCLE_IDX];
    endsequence

    property p_wrap;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && hit[`MBPT_CYCLE_IDX] && rst_bit[`MBPT_CYCLE_IDX] && !counter_reset)
        |=> (count_q == `MBPT_ZERO);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Count did not wrap.");

    property p_stop;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && stop) |=> halted_q ##1 (!clk_en || !tick);
    endproperty
    a_stop: assert property (p_stop) else $error("Stop on match failed.");

    property p_single_rise;
        @(posedge ref_clk) disable iff (rst)
        (s_cycle_end ##0 (pwm_out_en[0] && !hit[1] && active_q[1] != `MBPT_ZERO))
        |=> pwm_out_q[0];
    endproperty
    a_single_rise: assert property (p_single_rise) else $error("No rise at cycle.");

    property p_single_fall;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && hit[1]) |=> !pwm_out_q[0];
    endproperty
    a_single_fall: assert property (p_single_fall) else $error("No fall at match.");

    property p_double_rise;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && pwm_mode && pwm_dbl[2] && pwm_out_en[2] && hit[2] && !hit[3])
        |=> pwm_out_q[2];
    endproperty
    a_double_rise: assert property (p_double_rise) else $error("Double rise missed.");

    property p_hold_mid_cycle;
        @(posedge ref_clk) disable iff (rst)
        s_idle_mid_cycle |=> $stable(active_q[1]);
    endproperty
    a_hold_mid_cycle: assert property (p_hold_mid_cycle) else $error("Early update.");

    property p_unreleased;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && !release_q[2]) |=> $stable(active_q[2]);
    endproperty
    a_unreleased: assert property (p_unreleased) else $error("Unreleased applied.");

    property p_plain_timer;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && !pwm_mode) |=> (pwm_out_q == '0);
    endproperty
    a_plain_timer: assert property (p_plain_timer) else $error("PWM out in timer use.");

    property p_capture;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && cap_ev[1]) |=> (cap_val_q[2*`MBPT_W-1:`MBPT_W] == $past(count_q));
    endproperty
    a_capture: assert property (p_capture) else $error("Capture value wrong.");

    property p_toggle;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && hit[0] && ext_action[1:0] == `MBPT_EM_TOG)
        |=> (ext_match_q[0] != $past(ext_match_q[0]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("Toggle missed.");

    property p_flag_wins;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && flag_set[0]) |=> (flags_q[0] && irq_q);
    endproperty
    a_flag_wins: assert property (p_flag_wins) else $error("Flag set lost.");

    property p_sync_out;
        @(posedge ref_clk) disable iff (rst)
        (clk_en && run_req) |=> sync_run_out_q;
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("Sync run not driven.");
endmodule

`default_nettype wire

// >>> tb_match_based_pwm_timer.sv
`include "mbpt_defs.svh"
`default_nettype none

module tb_match_based_pwm_timer;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk, rst, run_req, counter_reset, pwm_mode, match_wr_stb, irq_q, halted_q;
    logic [1:0] src_mode, src_sel;
    logic [2:0] match_wr_idx, lsel;
    logic [5:0] pwm_dbl, pwm_out_en, pwm_out_q;
    logic [6:0] match_release, release_q;
    logic [7:0] ext_action;
    logic [3:0] cap_in, cap_rise_en, cap_int_en, ext_match_q;
    logic [10:0] flag_clear, flags_q;
    logic [20:0] match_ctrl;
    logic [31:0] presc_max, match_wr_data, count_q, meas_per, meas_high, w;
    logic [127:0] cap_val_q;
    logic meas_vld, sync_run;
    logic [63:0] exp_q[$];
    logic [1:0] acts [5] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
    logic [31:0] exps [5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    mbpt_timer dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .run_req(run_req),
        .counter_reset(counter_reset), .sync_follow(1'b0), .sync_run_in(1'b0),
        .src_mode(src_mode), .src_sel(src_sel), .presc_max(presc_max), .pwm_mode(pwm_mode),
        .pwm_dbl(pwm_dbl), .pwm_out_en(pwm_out_en), .match_wr_stb(match_wr_stb),
        .match_wr_idx(match_wr_idx), .match_wr_data(match_wr_data),
        .match_release(match_release), .match_ctrl(match_ctrl), .ext_action(ext_action),
        .cap_in(cap_in), .cap_rise_en(cap_rise_en), .cap_fall_en(4'h0),
        .cap_int_en(cap_int_en), .flag_clear(flag_clear), .count_q(count_q),
        .pwm_out_q(pwm_out_q), .ext_match_q(ext_match_q), .cap_val_q(cap_val_q),
        .flags_q(flags_q), .irq_q(irq_q), .sync_run_out_q(sync_run), .halted_q(halted_q),
        .release_q(release_q));

    mbpt_load load (.ref_clk(ref_clk), .rst(rst), .pwm(pwm_out_q), .sel(lsel),
        .meas_vld(meas_vld), .meas_per(meas_per), .meas_high(meas_high));

    // ****************************************************************
    // Checking and closing tasks.
    // ****************************************************************
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pwm(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic setm(input logic [2:0] idx, input logic [31:0] val, input logic rel);
        match_wr_stb = 1'b1;
        match_wr_idx = idx;
        match_wr_data = val;
        cyc(1);
        match_wr_stb = 1'b0;
        match_release[idx] = rel;
        cyc(1);
        match_release = 7'h00;
    endtask

    task automatic expect_pwm(input logic [31:0] per, input logic [31:0] high);
        exp_q.push_back({per, high});
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
            cyc(1);
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, 32'h0, per);
            exp_q.delete();
        end
    endtask

    // ****************************************************************
    // Clock, result watcher and hang limit.
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (meas_vld === 1'b1 && exp_q.size() > 0) begin
            chk_pwm({meas_per, meas_high}, exp_q.pop_front());
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, cycles, 32'h0);
            stop_test();
        end
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {rst, run_req, counter_reset, pwm_mode, match_wr_stb} = 5'h10;
        {src_mode, src_sel, match_wr_idx, lsel, pwm_dbl, pwm_out_en} = '0;
        {match_release, ext_action, cap_in, cap_rise_en, cap_int_en} = '0;
        {flag_clear, match_ctrl, presc_max, match_wr_data} = '0;
        void'($urandom(92));
        cyc(10);
        rst = 1'b0;
        pwm_mode = 1'b1;
        pwm_out_en = 6'h3F;
        match_ctrl = 21'h2;
        run_req = 1'b1;
        w = 32'h1 + ($urandom % 32'h8);
        setm(3'h0, 32'h9, 1'b1);
        setm(3'h1, w, 1'b1);
        cyc(30);
        expect_pwm(32'hA, w + 32'h1);
        chk({31'h0, sync_run}, 32'h1);
        $display("test single edge done");
        setm(3'h1, 32'h9 - w, 1'b0);
        cyc(30);
        chk({25'h0, release_q}, 32'h0);
        expect_pwm(32'hA, w + 32'h1);
        match_release = 7'h02;
        cyc(1);
        match_release = 7'h00;
        cyc(25);
        expect_pwm(32'hA, 32'hA - w);
        $display("test release done");
        lsel = 3'h2;
        pwm_dbl = 6'h04;
        setm(3'h2, 32'h2, 1'b1);
        setm(3'h3, 32'h6, 1'b1);
        cyc(30);
        expect_pwm(32'hA, 32'h4);
        setm(3'h2, 32'h7, 1'b1);
        setm(3'h3, 32'h2, 1'b1);
        cyc(30);
        expect_pwm(32'hA, 32'h5);
        $display("test double edge done");
        pwm_mode = 1'b0;
        match_ctrl = 21'h0;
        run_req = 1'b0;
        src_mode = 2'h1;
        presc_max = 32'h1;
        counter_reset = 1'b1;
        cyc(1);
        counter_reset = 1'b0;
        run_req = 1'b1;
        cyc(3);
        repeat (10) begin
            cap_in[0] = 1'b1;
            cyc(2);
            cap_in[0] = 1'b0;
            cyc(2);
        end
        cyc(3);
        chk(count_q, 32'h5);
        chk({26'h0, pwm_out_q}, 32'h0);
        flag_clear = 11'h7FF;
        cyc(1);
        flag_clear = 11'h000;
        cap_rise_en = 4'h2;
        cap_int_en = 4'h2;
        cap_in[1] = 1'b1;
        cyc(4);
        chk(cap_val_q[63:32], 32'h5);
        chk({21'h0, flags_q}, 32'h100);
        chk({31'h0, irq_q}, 32'h1);
        flag_clear[8] = 1'b1;
        cyc(1);
        flag_clear = 11'h000;
        cyc(2);
        chk({31'h0, irq_q}, 32'h0);
        $display("test counter and capture done");
        cap_in = 4'h0;
        src_mode = 2'h0;
        presc_max = 32'h0;
        match_ctrl = 21'h5;
        for (int i = 0; i < 5; i++) begin
            ext_action = {6'h00, acts[i]};
            counter_reset = 1'b1;
            cyc(1);
            counter_reset = 1'b0;
            cyc(20);
            chk({31'h0, ext_match_q[0]}, exps[i]);
            chk({31'h0, halted_q}, 32'h1);
        end
        chk({31'h0, flags_q[0]}, 32'h1);
        $display("test stop and external outputs done");
        stop_test();
    end
endmodule

`default_nettype wire
